// *** logic/cpo_pkg.sv ***
// constants, types and helpers shared by the pointer and register op group
// What this block does
// RULE_01: field shift-right of C drops one digit, zero enters field top digit
// RULE_02: C and flag byte swap in one cycle, legal right after arithmetic
// RULE_03: table read takes two cycles, C digits 6..3 addressed in the second
// RULE_04: fetched word lands in C digits 2..0, top two bits forced zero
// RULE_05: fetch marker output withheld while table read word is on the bus
// RULE_06: pointer load copies C digits 2..0 into register address pointer
// RULE_07: register address pointer lives at memory location 804000 hex
// RULE_08: register store writes C to pointed register over RAM bus, RAM select on
// RULE_09: in turbo, store runs at bus speed for unimplemented or peripheral register
// RULE_10: pointer step down moves to next lower digit in one cycle, no subtraction
// RULE_11: pointer codes map to digit positions 0 through 13 as tabled
// RULE_12: step down of codes 0000 through 0110 follows the lower table half
// RULE_13: step down of codes 1000 through 1110 follows upper half, digit 0 wraps to 13
// RULE_14: display off is a one-cycle bus-speed no-op; display controller blanks
// RULE_15: carry flag is cleared at the end of every instruction in the group
// RULE_16: swap exchanges C digits 1..0 with flag byte bits 7..0 only
package cpo_pkg;

  localparam int          DIGITS       = 14;
  localparam int          DIGIT_W      = 4;
  localparam int          C_W          = DIGITS * DIGIT_W;
  localparam int          FLAG_W       = 14;
  localparam int          SWAP_W       = 8;
  localparam int          INSTR_W      = 10;
  localparam int          RADDR_W      = 12;
  localparam int          MADDR_W      = 24;
  localparam int          ISA_W        = 16;

  // instruction encodings
  localparam logic [9:0]  OP_SHIFT_MASK = 10'h3E3;
  localparam logic [9:0]  OP_SHIFT_VAL  = 10'h3C2;
  localparam logic [9:0]  OP_SWAP       = 10'h3D8;
  localparam logic [9:0]  OP_TABLE      = 10'h330;
  localparam logic [9:0]  OP_LOAD_PTR   = 10'h270;
  localparam logic [9:0]  OP_STORE      = 10'h2F0;
  localparam logic [9:0]  OP_PTR_DOWN   = 10'h3D4;
  localparam logic [9:0]  OP_DISP_OFF   = 10'h2E0;
  localparam int          FSEL_LSB      = 2;

  // field positions inside C
  localparam int          TBL_ADDR_LSB  = 12;
  localparam int          LOW3_W        = 12;
  localparam logic [1:0]  WORD_PAD      = 2'h0;
  localparam logic [MADDR_W-1:0] REG_PTR_LOC = 24'h804000;
  localparam logic [11:0] RAM_BASE_HI   = 12'h000;

  // field select codes
  localparam logic [2:0]  FS_PT   = 3'h0;
  localparam logic [2:0]  FS_X    = 3'h1;
  localparam logic [2:0]  FS_WPT  = 3'h2;
  localparam logic [2:0]  FS_W    = 3'h3;
  localparam logic [2:0]  FS_PQ   = 3'h4;
  localparam logic [2:0]  FS_XS   = 3'h5;
  localparam logic [2:0]  FS_M    = 3'h6;
  localparam logic [2:0]  FS_S    = 3'h7;
  localparam logic [3:0]  DG_0    = 4'h0;
  localparam logic [3:0]  DG_2    = 4'h2;
  localparam logic [3:0]  DG_3    = 4'h3;
  localparam logic [3:0]  DG_12   = 4'hC;
  localparam logic [3:0]  DG_13   = 4'hD;

  // reset values
  localparam logic [3:0]  PTR_RESET = 4'hE;

  typedef enum logic [0:0] {
    PH_IDLE  = 1'b0,
    PH_TABLE = 1'b1
  } cpo_phase_t;

  typedef struct packed {
    logic               valid;
    logic [INSTR_W-1:0] code;
  } cpo_instr_t;

  typedef struct packed {
    logic [MADDR_W-1:0] addr;
    logic [C_W-1:0]     wdata;
    logic               ram_cs;
    logic               we;
  } cpo_mem_bus_t;

  // pointer code to digit position
  function automatic logic [3:0] ptr_digit(input logic [3:0] p);
    unique case (p)
      4'hE: ptr_digit = 4'h0; // RULE_11
      4'hC: ptr_digit = 4'h1;
      4'h8: ptr_digit = 4'h2;
      4'h0: ptr_digit = 4'h3;
      4'h1: ptr_digit = 4'h4;
      4'h2: ptr_digit = 4'h5;
      4'h5: ptr_digit = 4'h6;
      4'hA: ptr_digit = 4'h7;
      4'h4: ptr_digit = 4'h8;
      4'h9: ptr_digit = 4'h9;
      4'h3: ptr_digit = 4'hA;
      4'h6: ptr_digit = 4'hB;
      4'hD: ptr_digit = 4'hC;
      4'hB: ptr_digit = 4'hD;
      default: ptr_digit = 4'h0;
    endcase
  endfunction

  // next lower digit position; unused codes 0111 and 1111 stay put
  function automatic logic [3:0] ptr_down(input logic [3:0] p);
    unique case (p)
      4'h0: ptr_down = 4'h8; // RULE_12
      4'h1: ptr_down = 4'h0;
      4'h2: ptr_down = 4'h1;
      4'h3: ptr_down = 4'h9;
      4'h4: ptr_down = 4'hA;
      4'h5: ptr_down = 4'h2;
      4'h6: ptr_down = 4'h3;
      4'h8: ptr_down = 4'hC; // RULE_13
      4'h9: ptr_down = 4'h4;
      4'hA: ptr_down = 4'h5;
      4'hB: ptr_down = 4'hD;
      4'hC: ptr_down = 4'hE;
      4'hD: ptr_down = 4'h6;
      4'hE: ptr_down = 4'hB; // RULE_13
      default: ptr_down = p;
    endcase
  endfunction

endpackage

// *** logic/cpo_reg_class.sv ***
// classifies a register address as fast RAM or bus-speed target
module cpo_reg_class #(
  parameter logic [11:0] IMPL_LIMIT  = 12'h200,
  parameter logic [11:0] PERIPH_BASE = 12'h0F0,
  parameter logic [11:0] PERIPH_TOP  = 12'h0FF
) (
  input  wire logic [11:0] reg_addr,
  output logic             slow_target
);
  // peripheral window sits inside the implemented range, so it is ORed with the limit test
  always_comb begin
    slow_target = (reg_addr >= IMPL_LIMIT) ||
                  ((reg_addr >= PERIPH_BASE) && (reg_addr <= PERIPH_TOP));
  end
endmodule

// *** logic/cpo_exec.sv ***
// execution of the field shift, swap, table read, pointer and store ops
module cpo_exec #(
  parameter logic [11:0] IMPL_LIMIT  = 12'h200,
  parameter logic [11:0] PERIPH_BASE = 12'h0F0,
  parameter logic [11:0] PERIPH_TOP  = 12'h0FF
) (
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      clk_en,
  input  wire cpo_pkg::cpo_instr_t       instr,
  input  wire logic                      fetch_in,
  input  wire logic                      turbo_mode,
  input  wire logic [cpo_pkg::INSTR_W-1:0] isa_data,
  input  wire logic                      c_load,
  input  wire logic [cpo_pkg::C_W-1:0]   c_wdata,
  input  wire logic                      flag_load,
  input  wire logic [cpo_pkg::FLAG_W-1:0] flag_wdata,
  input  wire logic                      ptr_load,
  input  wire logic [3:0]                ptr_wdata,
  input  wire logic                      carry_set,
  output logic [cpo_pkg::C_W-1:0]        c_reg,
  output logic [cpo_pkg::FLAG_W-1:0]     flag_byte,
  output logic [3:0]                     ptr,
  output logic [cpo_pkg::RADDR_W-1:0]    reg_ptr,
  output logic                           carry,
  output logic                           busy,
  output logic                           fetch_marker,
  output logic [cpo_pkg::ISA_W-1:0]      isa_addr,
  output logic                           isa_addr_en,
  output cpo_pkg::cpo_mem_bus_t          mem_bus,
  output logic                           bus_speed,
  output logic                           done
);
  import cpo_pkg::*;

  typedef struct packed {
    cpo_phase_t            phase;
    logic [C_W-1:0]        c;
    logic [FLAG_W-1:0]     flags;
    logic [3:0]            ptr;
    logic [RADDR_W-1:0]    reg_ptr;
    logic                  carry;
    logic [ISA_W-1:0]      isa_addr;
    logic                  isa_addr_en;
    cpo_mem_bus_t          mem;
    logic                  bus_speed;
    logic                  done;
  } cpo_state_t;

  cpo_state_t state;
  cpo_state_t next_state;
  logic       slow_target;
  logic       accept;

  // lower and upper digit of the selected field
  function automatic logic [7:0] field_bounds(input logic [2:0] fs,
                                              input logic [3:0] pdig);
    logic [3:0] lo;
    logic [3:0] hi;
    lo = DG_0;
    hi = DG_13;
    unique case (fs)
      FS_PT:  begin
        lo = pdig;
        hi = pdig;
      end
      FS_X:   begin
        lo = DG_0;
        hi = DG_2;
      end
      FS_WPT: begin
        lo = DG_0;
        hi = pdig;
      end
      FS_W:   begin
        lo = DG_0;
        hi = DG_13;
      end
      FS_PQ:  begin
        lo = pdig;
        hi = DG_13;
      end
      FS_XS:  begin
        lo = DG_2;
        hi = DG_2;
      end
      FS_M:   begin
        lo = DG_3;
        hi = DG_12;
      end
      FS_S:   begin
        lo = DG_13;
        hi = DG_13;
      end
    endcase
    field_bounds = {hi, lo};
  endfunction

  // one-digit right shift inside [lo, hi], zero into the top digit
  function automatic logic [C_W-1:0] shift_field(input logic [C_W-1:0] c,
                                                 input logic [3:0]     lo,
                                                 input logic [3:0]     hi);
    logic [C_W-1:0] r;
    logic [C_W-1:0] s;
    r = c;
    // pre-shifted copy keeps every digit select inside the vector
    s = c >> DIGIT_W;
    for (int i = 0; i < DIGITS; i++) begin
      if ((4'(i) >= lo) && (4'(i) <= hi)) begin
        if (4'(i) == hi) begin
          r[i*DIGIT_W +: DIGIT_W] = DG_0; // RULE_01
        end else begin
          r[i*DIGIT_W +: DIGIT_W] = s[i*DIGIT_W +: DIGIT_W]; // RULE_01
        end
      end
    end
    shift_field = r;
  endfunction

  // register class lookup for the turbo speed decision
  cpo_reg_class #(
    .IMPL_LIMIT  (IMPL_LIMIT),
    .PERIPH_BASE (PERIPH_BASE),
    .PERIPH_TOP  (PERIPH_TOP)
  ) u_class (
    .reg_addr    (state.reg_ptr),
    .slow_target (slow_target)
  );

  // new instructions are ignored while the table read occupies its second cycle
  assign accept = instr.valid && (state.phase == PH_IDLE);

  // next state
  always_comb begin
    logic [7:0] bounds;
    bounds = field_bounds(instr.code[FSEL_LSB +: 3], ptr_digit(state.ptr)); // RULE_11
    next_state = state;
    // bus strobes and pulses last one cycle
    next_state.mem.we      = 1'b0;
    next_state.mem.ram_cs  = 1'b0;
    next_state.isa_addr_en = 1'b0;
    next_state.bus_speed   = 1'b0;
    next_state.done        = 1'b0;
    if (c_load) begin
      next_state.c = c_wdata;
    end
    if (flag_load) begin
      next_state.flags = flag_wdata;
    end
    if (ptr_load) begin
      next_state.ptr = ptr_wdata;
    end
    // carry comes from the rest of the datapath; a group op below still clears it
    if (carry_set) begin
      next_state.carry = 1'b1;
    end
    if (state.phase == PH_TABLE) begin
      // word sampled at the end of the address cycle
      next_state.c[LOW3_W-1:0] = {WORD_PAD, isa_data}; // RULE_04
      next_state.carry = 1'b0; // RULE_15
      next_state.done  = 1'b1;
      next_state.phase = PH_IDLE; // RULE_03
    end else if (accept) begin
      if ((instr.code & OP_SHIFT_MASK) == OP_SHIFT_VAL) begin
        next_state.c = shift_field(state.c, bounds[3:0], bounds[7:4]); // RULE_01
        next_state.carry = 1'b0; // RULE_15
        next_state.done  = 1'b1;
      end else begin
        unique case (instr.code)
          OP_SWAP: begin
            // no pipeline hazard to guard: swap reads registered C directly
            next_state.c[SWAP_W-1:0]     = state.flags[SWAP_W-1:0]; // RULE_02
            next_state.flags[SWAP_W-1:0] = state.c[SWAP_W-1:0]; // RULE_16
            next_state.carry = 1'b0; // RULE_15
            next_state.done  = 1'b1;
          end
          OP_TABLE: begin
            // address goes out registered, so it stands during cycle two
            next_state.isa_addr    = state.c[TBL_ADDR_LSB +: ISA_W]; // RULE_03
            next_state.isa_addr_en = 1'b1; // RULE_03
            next_state.phase       = PH_TABLE; // RULE_03
          end
          OP_LOAD_PTR: begin
            next_state.reg_ptr   = state.c[RADDR_W-1:0]; // RULE_06
            next_state.mem.addr  = REG_PTR_LOC; // RULE_07
            next_state.mem.wdata = {{(C_W-RADDR_W){1'b0}}, state.c[RADDR_W-1:0]}; // RULE_07
            next_state.mem.we    = 1'b1; // RULE_07
            next_state.carry = 1'b0; // RULE_15
            next_state.done  = 1'b1;
          end
          OP_STORE: begin
            next_state.mem.addr   = {RAM_BASE_HI, state.reg_ptr}; // RULE_08
            next_state.mem.wdata  = state.c; // RULE_08
            next_state.mem.we     = 1'b1; // RULE_08
            next_state.mem.ram_cs = 1'b1; // RULE_08
            next_state.bus_speed  = turbo_mode && slow_target; // RULE_09
            next_state.carry = 1'b0; // RULE_15
            next_state.done  = 1'b1;
          end
          OP_PTR_DOWN: begin
            next_state.ptr   = ptr_down(state.ptr); // RULE_10
            next_state.carry = 1'b0; // RULE_15
            next_state.done  = 1'b1;
          end
          OP_DISP_OFF: begin
            // nothing for the core; the display controller watches the stream
            next_state.bus_speed = turbo_mode; // RULE_14
            next_state.carry = 1'b0; // RULE_15
            next_state.done  = 1'b1;
          end
          default: begin
            next_state.done = 1'b0;
          end
        endcase
      end
    end
  end

  // state register, frozen while clk_en is low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state.phase       <= PH_IDLE;
      state.c           <= '0;
      state.flags       <= '0;
      state.ptr         <= PTR_RESET;
      state.reg_ptr     <= '0;
      state.carry       <= 1'b0;
      state.isa_addr    <= '0;
      state.isa_addr_en <= 1'b0;
      state.mem         <= '0;
      state.bus_speed   <= 1'b0;
      state.done        <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // marker blanked while the table word is on the program bus
  assign fetch_marker = fetch_in && (state.phase != PH_TABLE); // RULE_05
  assign busy         = (state.phase == PH_TABLE);
  assign c_reg        = state.c;
  assign flag_byte    = state.flags;
  assign ptr          = state.ptr;
  assign reg_ptr      = state.reg_ptr;
  assign carry        = state.carry;
  assign isa_addr     = state.isa_addr;
  assign isa_addr_en  = state.isa_addr_en;
  assign mem_bus      = state.mem;
  assign bus_speed    = state.bus_speed;
  assign done         = state.done;

endmodule

// *** test/cpo_exec_assertions.sv ***
// assertion checker watching the ports of the op group executor
module cpo_exec_assertions (
  input wire logic                          clk_sys,
  input wire logic                          nrst,
  input wire logic                          clk_en,
  input wire cpo_pkg::cpo_instr_t           instr,
  input wire logic                          turbo_mode,
  input wire logic [cpo_pkg::INSTR_W-1:0]   isa_data,
  input wire logic [cpo_pkg::C_W-1:0]       c_reg,
  input wire logic [cpo_pkg::FLAG_W-1:0]    flag_byte,
  input wire logic [cpo_pkg::RADDR_W-1:0]   reg_ptr,
  input wire logic                          carry,
  input wire logic                          busy,
  input wire logic                          fetch_marker,
  input wire logic [cpo_pkg::ISA_W-1:0]     isa_addr,
  input wire logic                          isa_addr_en,
  input wire cpo_pkg::cpo_mem_bus_t         mem_bus,
  input wire logic                          bus_speed,
  input wire logic                          done
);
  timeunit 1ns;
  timeprecision 100ps;
  import cpo_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // an op is taken only when idle and enabled
  sequence take(logic [9:0] op);
    clk_en && instr.valid && !busy && instr.code == op;
  endsequence
  // second cycle of the table read, then completion
  sequence tbl_steps;
    busy && isa_addr_en && !fetch_marker ##1 !busy && done;
  endsequence
  table_steps_a: assert property (take(OP_TABLE) |=> tbl_steps)
    else $error("table read cycle sequence wrong");
  table_addr_a: assert property (take(OP_TABLE) |=> isa_addr == $past(c_reg[27:12]))
    else $error("table read address wrong");
  word_pad_a: assert property (take(OP_TABLE) ##1 1'b1 |=> c_reg[11:0] == {2'h0, $past(isa_data)})
    else $error("fetched word not right justified");
  fetch_hold_a: assert property (busy |-> !fetch_marker)
    else $error("fetch marker shown during table read");
  ptr_load_a: assert property (take(OP_LOAD_PTR) |=> reg_ptr == $past(c_reg[11:0])
    && mem_bus.addr == 24'h804000)
    else $error("register pointer load wrong");
  store_cs_a: assert property (take(OP_STORE) |=> mem_bus.ram_cs && mem_bus.we
    && mem_bus.wdata == $past(c_reg) && mem_bus.addr == {12'h000, $past(reg_ptr)})
    else $error("register store bus cycle wrong");
  store_speed_a: assert property (take(OP_STORE) |=> bus_speed == $past(turbo_mode
    && (reg_ptr >= 12'h200 || reg_ptr[11:4] == 8'h0F)))
    else $error("store speed choice wrong");
  swap_bytes_a: assert property (take(OP_SWAP) |=> c_reg[7:0] == $past(flag_byte[7:0])
    && flag_byte == {$past(flag_byte[13:8]), $past(c_reg[7:0])})
    else $error("swap result wrong");
  carry_clear_a: assert property (done |-> !carry)
    else $error("carry set at completion");
  disp_off_a: assert property (take(OP_DISP_OFF) |=> done && bus_speed == $past(turbo_mode))
    else $error("display off handling wrong");
endmodule

// *** test/cpo_partner.sv ***
// program memory, register ram and display controller beside the op group
module cpo_partner (
  input wire logic                          clk_sys,
  input wire logic [cpo_pkg::ISA_W-1:0]     isa_addr,
  input wire logic                          isa_addr_en,
  input wire cpo_pkg::cpo_mem_bus_t         mem_bus,
  input wire cpo_pkg::cpo_instr_t           instr,
  input wire logic                          fetch_marker,
  output logic [cpo_pkg::INSTR_W-1:0]       isa_data,
  output logic [cpo_pkg::C_W-1:0]           ram_word,
  output logic [cpo_pkg::RADDR_W-1:0]       ram_addr,
  output logic [cpo_pkg::RADDR_W-1:0]       ptr_word,
  output logic                              display_on
);
  timeunit 1ns;
  timeprecision 100ps;
  import cpo_pkg::*;
  logic flip = 1'b0;
  initial display_on = 1'b1;
  initial ram_word = '0;
  initial ram_addr = '0;
  initial ptr_word = '0;
  // undriven bus toggles so a stale word cannot pass for data
  assign isa_data = isa_addr_en ? (isa_addr[9:0] ^ 10'h2A5) : {5{flip, ~flip}};
  // ram captures selected writes, pointer cell sits outside ram select
  always @(posedge clk_sys) begin
    flip <= ~flip;
    if (mem_bus.we && mem_bus.ram_cs) begin
      ram_addr <= mem_bus.addr[11:0];
      ram_word <= mem_bus.wdata;
    end
    if (mem_bus.we && !mem_bus.ram_cs && mem_bus.addr == 24'h804000)
      ptr_word <= mem_bus.wdata[11:0];
    if (fetch_marker && instr.valid && instr.code == 10'h2E0)
      display_on <= 1'b0;
  end
endmodule

// *** test/calc_cpu_register_pointer_ops_tb.sv ***
// self-checking bench for the pointer and register op group
module calc_cpu_register_pointer_ops_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cpo_pkg::*;
  logic clk_sys, nrst, clk_en, fetch_in, turbo_mode, c_load, flag_load, ptr_load, carry_set;
  logic carry, busy, fetch_marker, isa_addr_en, bus_speed, done, display_on;
  cpo_instr_t         instr;
  cpo_mem_bus_t       mem_bus;
  logic [INSTR_W-1:0] isa_data;
  logic [ISA_W-1:0]   isa_addr;
  logic [C_W-1:0]     c_wdata, c_reg, ram_word, mc;
  logic [FLAG_W-1:0]  flag_wdata, flag_byte, mf;
  logic [3:0]         ptr_wdata, ptr, mp, p;
  logic [11:0]        reg_ptr, ram_addr, ptr_word, mr, a;
  logic [63:0]        rnd;
  logic [7:0]         tmp;
  logic [12:0]        e;
  int                 errors, total_checks, cycles, lo, hi, d;
  // pointer code to digit, and code to next lower code
  localparam logic [63:0] DTAB = 64'h00C1D7920B68A543;
  localparam logic [63:0] NTAB = 64'hFB6ED54C732A9108;
  localparam logic [51:0] STV = {13'h10F5, 13'h1010, 13'h12A0, 13'h00F5};

  cpo_exec dut (.clk_sys, .nrst, .clk_en, .instr, .fetch_in, .turbo_mode, .isa_data,
    .c_load, .c_wdata, .flag_load, .flag_wdata, .ptr_load, .ptr_wdata, .carry_set, .c_reg,
    .flag_byte, .ptr, .reg_ptr, .carry, .busy, .fetch_marker, .isa_addr,
    .isa_addr_en, .mem_bus, .bus_speed, .done);
  cpo_partner far (.clk_sys, .isa_addr, .isa_addr_en, .mem_bus, .instr, .fetch_marker,
    .isa_data, .ram_word, .ram_addr, .ptr_word, .display_on);

  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // hang guard, the run needs well under a hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 2000) begin
      errors++;
      give_verdict;
    end
  end

  task give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc;
    @(posedge clk_sys);
    #2;
  endtask
  // offer one op; keep leaves it up so the next op follows back to back
  task op(input logic [9:0] code, input bit keep);
    instr = '{1'b1, code};
    cyc;
    if (!keep) instr.valid = 1'b0;
  endtask
  task ldall(input logic [55:0] c, input logic [13:0] f, input logic [3:0] q);
    {c_load, flag_load, ptr_load, carry_set} = 4'hF;
    {c_wdata, flag_wdata, ptr_wdata} = {c, f, q};
    {mc, mf, mp} = {c, f, q};
    cyc;
    {c_load, flag_load, ptr_load, carry_set} = 4'h0;
  endtask
  // completion state against the model
  task fin;
    chk(done, 1);
    chk(carry, 0);
    chk(c_reg, mc);
    chk(flag_byte, mf);
    chk(ptr, mp);
    chk(reg_ptr, mr);
  endtask
  function automatic logic [55:0] shr(input logic [55:0] c, input int l, input int h);
    for (int i = l; i <= h; i++) c[4*i+:4] = (i == h) ? 4'h0 : c[4*i+4+:4];
    return c;
  endfunction

  initial begin
    {nrst, fetch_in, clk_en, turbo_mode} = 4'h6;
    {c_load, flag_load, ptr_load, carry_set} = 4'h0;
    {c_wdata, flag_wdata, ptr_wdata} = '0;
    instr = '0;
    {mc, mf, mr} = '0;
    rnd[31:0] = $urandom(32'h4F56);
    repeat (2) @(posedge clk_sys);
    #2 nrst = 1'b1;
    cyc;
    chk(ptr, 4'hE);
    // clock enable low: an offered op must not land, marker follows its input
    {clk_en, fetch_in} = 2'h0;
    op(OP_PTR_DOWN, 0);
    chk({done, ptr, fetch_marker}, {1'b0, 4'hE, 1'b0});
    {clk_en, fetch_in} = 2'h3;
    // every field select, pointer digit from the code table
    for (int fs = 0; fs < 8; fs++) begin
      rnd = {$urandom, $urandom};
      p = (rnd[3:0] == 4'h7 || rnd[3:0] == 4'hF) ? 4'hE : rnd[3:0];
      ldall(rnd[55:0], rnd[63:50], p);
      d = DTAB[4*mp+:4];
      lo = (fs == 0 || fs == 4) ? d : (fs == 5) ? 2 : (fs == 6) ? 3 : (fs == 7) ? 13 : 0;
      hi = (fs == 0 || fs == 2) ? d : (fs == 1 || fs == 5) ? 2 : (fs == 6) ? 12 : 13;
      op(10'h3C2 | 10'(fs << 2), fs == 7);
      mc = shr(mc, lo, hi);
      fin;
    end
    // swap straight after the shift
    op(OP_SWAP, 0);
    tmp = mc[7:0];
    mc[7:0] = mf[7:0];
    mf[7:0] = tmp;
    fin;
    // table read with the fetch marker requested throughout
    // a step down offered during the busy cycle must be ignored
    op(OP_TABLE, 1);
    instr.code = OP_PTR_DOWN;
    chk(busy, 1);
    chk(fetch_marker, 0);
    chk({isa_addr_en, isa_addr}, {1'b1, mc[27:12]});
    cyc;
    instr.valid = 1'b0;
    mc[11:0] = {2'h0, mc[21:12] ^ 10'h2A5};
    fin;
    // every code through the step down, unused codes included
    for (int k = 0; k < 16; k++) begin
      ldall(mc, mf, 4'(k));
      op(OP_PTR_DOWN, 0);
      mp = NTAB[4*k+:4];
      fin;
    end
    // pointer load then store, fast, peripheral and unimplemented targets
    for (int k = 0; k < 4; k++) begin
      e = STV[13*k+:13];
      a = e[11:0];
      turbo_mode = e[12];
      rnd = {$urandom, $urandom};
      ldall({rnd[55:12], a}, mf, mp);
      op(OP_LOAD_PTR, 1);
      mr = a;
      fin;
      chk(mem_bus.addr, 24'h804000);
      op(OP_STORE, 0);
      chk(bus_speed, e[12] && (a >= 12'h200 || a[11:4] == 8'h0F));
      chk({mem_bus.ram_cs, mem_bus.we}, 2'h3);
      fin;
      cyc;
      chk({ram_addr, ptr_word}, {a, a});
      chk(ram_word, mc);
    end
    turbo_mode = 1'b1;
    op(OP_DISP_OFF, 0);
    chk({bus_speed, display_on}, 2'h2);
    fin;
    cyc;
    give_verdict;
  end
endmodule

bind cpo_exec cpo_exec_assertions chk_i (.clk_sys, .nrst, .clk_en, .instr, .turbo_mode,
  .isa_data, .c_reg, .flag_byte, .reg_ptr, .carry, .busy, .fetch_marker, .isa_addr,
  .isa_addr_en, .mem_bus, .bus_speed, .done);
